// ### verilog/switch_timeout_pkg.sv
// Constants and carrier types for the switch time-out reporting block
package switch_timeout_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_TIMEOUT_CONTROL  = 12'h750;
    localparam logic [11:0] OFF_TIMEOUT_STATUS   = 12'h754;
    localparam logic [11:0] OFF_REPORT_CONTROL   = 12'h758;
    localparam logic [11:0] OFF_DISCARD_COUNTS   = 12'h75C;
    localparam logic [11:0] OFF_TIMESTAMP_CTRL   = 12'h760;
    // Field layout
    localparam int QUEUES      = 4;
    localparam int SEL_W       = 2;
    localparam int CNT_W       = 8;
    localparam int INC_LSB     = 0;
    localparam int INC_W       = 22;
    localparam int TERMINAL_COUNT_LSB  = 22;
    localparam int TERMINAL_COUNT_W    = 9;
    localparam int SLICE_LSB   = 24;
    localparam int TS_LOW_W    = 33;
    // Reset values and the counter maximum
    localparam logic [7:0]  CTRL_RESET   = 8'h82;
    localparam logic [21:0] INC_RESET    = 22'h00_0001;
    localparam logic [8:0]  TERMINAL_COUNT_RESET = 9'h1DD;
    localparam logic        ENABLE_RESET = 1'b1;
    localparam logic [7:0]  CNT_MAX      = 8'hFF;
    // Age in epochs after which a queued packet is dropped
    localparam logic [1:0]  AGE_EPOCHS   = 2'h2;
    // Reporting severities
    localparam logic [1:0]  SEV_NONE     = 2'h0;
    localparam logic [1:0]  SEV_COR      = 2'h1;
    localparam logic [1:0]  SEV_NONFATAL = 2'h2;
    localparam logic [1:0]  SEV_FATAL    = 2'h3;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Head of one input-buffer queue: valid and its arrival epoch
    typedef struct packed {
        logic       valid;
        logic [1:0] epoch;
    } head_t;

    // One error message toward the root
    typedef struct packed {
        logic       valid;
        logic [1:0] severity;
        logic [1:0] queue;
    } err_msg_t;
endpackage

// ### verilog/switch_timeout_report_stats.sv
// Switch time-out discard, reporting, statistics and time-stamp logic
//
// What this block does
// - Selector picks none, correctable, nonfatal, fatal message
// - Report only on status bit zero-to-one edge
// - Posted selector bits 1:0, resets nonfatal
// - Non-posted selector bits 3:2, resets none
// - Completion selector bits 5:4, resets none
// - Insertion selector bits 7:6, resets nonfatal
// - Per-queue 8-bit discard counters count drops
// - Discard counters saturate at all ones
// - Reading counters clears them; counters are sticky
// - Time stamp advances by step each clock below terminal count
// - Larger step shortens time-out; adds round up, plus one wrap clock
// - Slice at or above terminal count bumps epoch
// - Terminal count resets to 0x1DD
// - Packet times out after two epochs
// - Status bit set on drop, write-one clears
// - Dropping only while time-out enable set
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module switch_timeout_report_stats #(
    parameter int ADDR_W = 12
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          stickyRst_n,
    input  wire logic                          ce,
    input  wire logic [ADDR_W-1:0]             awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [ADDR_W-1:0]             araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    input  wire switch_timeout_pkg::head_t [3:0] queueHead,
    output logic [3:0]                         dropHead,
    output logic [1:0]                         epoch,
    output switch_timeout_pkg::err_msg_t       errMsg
);
    logic                    enableReg;
    logic [3:0]              statusReg;
    logic [3:0]              statusNext;
    logic [7:0]              reportCtrlReg;
    logic [3:0][7:0]         cntReg;
    logic [21:0]             incReg;
    logic [8:0]              tcountReg;
    logic [32:0]             lowReg;
    logic [1:0]              epochReg;
    logic [3:0]              dropReg;
    logic [3:0]              pendReg;
    logic [3:0]              pendNext;
    logic [3:0]              served;
    logic [1:0]              servedIdx;
    logic                    wrEn;
    logic                    rdEn;
    logic                    cntClr;
    logic [31:0]             tsWord;
    logic [31:0]             tsMerged;
    logic [31:0]             rdValue;
    logic                    rdHit;
    logic                    wrHit;

    // Two-bit selector of one queue out of the control byte
    function automatic logic [1:0] selOf(input logic [7:0] ctrl,
                                         input logic [1:0] idx);
        selOf = ctrl[idx*2 +: 2];
    endfunction

    // Byte-lane merge of a write into an old register word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = val[b*8 +: 8];
            end
        end
    endfunction

    // Word-aligned address match
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] off);
        hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    // Age check in modulo-4 epochs
    function automatic logic isOld(input logic [1:0] now,
                                   input logic [1:0] stamp);
        logic [1:0] age;
        age = now - stamp;
        isOld = (age >= switch_timeout_pkg::AGE_EPOCHS);
    endfunction

    // Handshake edges: the master holds payload until its ready edge
    assign wrEn   = awready && awvalid;
    assign rdEn   = arready && arvalid;
    assign cntClr = rdEn && hit(araddr, switch_timeout_pkg::OFF_DISCARD_COUNTS);
    assign wrHit  = hit(awaddr, switch_timeout_pkg::OFF_TIMEOUT_CONTROL)
                 || hit(awaddr, switch_timeout_pkg::OFF_TIMEOUT_STATUS)
                 || hit(awaddr, switch_timeout_pkg::OFF_REPORT_CONTROL)
                 || hit(awaddr, switch_timeout_pkg::OFF_DISCARD_COUNTS)
                 || hit(awaddr, switch_timeout_pkg::OFF_TIMESTAMP_CTRL);
    assign tsWord   = {1'b0, tcountReg, incReg};
    assign tsMerged = merge(tsWord, wdata, wstrb);

    // Write channel: address and data are taken together on one edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= switch_timeout_pkg::RESP_OKAY;
        end else if (ce) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (!awready && !bvalid && awvalid && wvalid) begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
            if (wrEn) begin
                bvalid <= 1'b1;
                bresp  <= wrHit ? switch_timeout_pkg::RESP_OKAY
                                : switch_timeout_pkg::RESP_SLVERR;
            end
        end
    end

    // Read data mux; reserved bits read as zero
    always_comb begin
        rdValue = 32'h0000_0000;
        rdHit   = 1'b1;
        if (hit(araddr, switch_timeout_pkg::OFF_TIMEOUT_CONTROL)) begin
            rdValue[0] = enableReg;
        end else if (hit(araddr, switch_timeout_pkg::OFF_TIMEOUT_STATUS)) begin
            rdValue[3:0] = statusReg;
        end else if (hit(araddr, switch_timeout_pkg::OFF_REPORT_CONTROL)) begin
            rdValue[7:0] = reportCtrlReg;
        end else if (hit(araddr, switch_timeout_pkg::OFF_DISCARD_COUNTS)) begin
            rdValue = cntReg;
        end else if (hit(araddr, switch_timeout_pkg::OFF_TIMESTAMP_CTRL)) begin
            rdValue = tsWord;
        end else begin
            rdHit = 1'b0;
        end
    end

    // Read channel; the clear-on-read side effect lands on the ready edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= switch_timeout_pkg::RESP_OKAY;
        end else if (ce) begin
            arready <= 1'b0;
            if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
            if (!arready && !rvalid && arvalid) begin
                arready <= 1'b1;
            end
            if (rdEn) begin
                rvalid <= 1'b1;
                rdata  <= rdValue;
                rresp  <= rdHit ? switch_timeout_pkg::RESP_OKAY
                                : switch_timeout_pkg::RESP_SLVERR;
            end
        end
    end

    // Sticky settings survive the ordinary reset, only power-on clears them
    always_ff @(posedge clk) begin
        if (!stickyRst_n) begin
            enableReg     <= switch_timeout_pkg::ENABLE_RESET;
            reportCtrlReg <= switch_timeout_pkg::CTRL_RESET;
            incReg        <= switch_timeout_pkg::INC_RESET;
            tcountReg     <= switch_timeout_pkg::TERMINAL_COUNT_RESET;
        end else if (ce && wrEn) begin
            if (hit(awaddr, switch_timeout_pkg::OFF_TIMEOUT_CONTROL)
                && wstrb[0]) begin
                enableReg <= wdata[0];
            end
            if (hit(awaddr, switch_timeout_pkg::OFF_REPORT_CONTROL)
                && wstrb[0]) begin
                reportCtrlReg <= wdata[7:0];
            end
            if (hit(awaddr, switch_timeout_pkg::OFF_TIMESTAMP_CTRL)) begin
                incReg    <= tsMerged[21:0];
                tcountReg <= tsMerged[30:22];
            end
        end
    end

    // Status: a drop in the clearing cycle still sets the bit
    always_comb begin
        statusNext = statusReg;
        if (wrEn && wstrb[0]
            && hit(awaddr, switch_timeout_pkg::OFF_TIMEOUT_STATUS)) begin
            statusNext = statusReg & ~wdata[3:0];
        end
        statusNext = statusNext | dropReg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            statusReg <= 4'h0;
        end else if (ce) begin
            statusReg <= statusNext;
        end
    end

    // Pending reports: set on a rising status bit, served lowest first
    always_comb begin
        served    = pendReg & (~pendReg + 4'h1);
        servedIdx = 2'h0;
        for (int q = 3; q >= 0; q--) begin
            if (served[q]) begin
                servedIdx = q[1:0];
            end
        end
        pendNext = pendReg & ~served;
        for (int q = 0; q < 4; q++) begin
            if (statusNext[q] && !statusReg[q]
                && selOf(reportCtrlReg, q[1:0]) != switch_timeout_pkg::SEV_NONE) begin
                pendNext[q] = 1'b1;
            end
        end
    end

    // One message per cycle; severity taken from the live selector
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pendReg <= 4'h0;
            errMsg  <= '0;
        end else if (ce) begin
            pendReg         <= pendNext;
            // A selector cleared while pending suppresses the message
            errMsg.valid    <= |pendReg && selOf(reportCtrlReg, servedIdx)
                               != switch_timeout_pkg::SEV_NONE;
            errMsg.queue    <= servedIdx;
            errMsg.severity <= selOf(reportCtrlReg, servedIdx);
        end
    end

    // Drop request: at most every other cycle so the queue can pop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dropReg <= 4'h0;
        end else if (ce) begin
            for (int q = 0; q < 4; q++) begin
                dropReg[q] <= enableReg && queueHead[q].valid
                           && isOld(epochReg, queueHead[q].epoch)
                           && !dropReg[q];
            end
        end
    end

    // Saturating clear-on-read counters, sticky over ordinary reset
    always_ff @(posedge clk) begin
        if (!stickyRst_n) begin
            cntReg <= '0;
        end else if (ce) begin
            for (int q = 0; q < 4; q++) begin
                if (cntClr) begin
                    cntReg[q] <= dropReg[q] ? 8'h01 : 8'h00;
                end else if (dropReg[q]
                             && cntReg[q] != switch_timeout_pkg::CNT_MAX) begin
                    cntReg[q] <= cntReg[q] + 8'h01;
                end
            end
        end
    end

    // Time stamp; a larger step reaches the terminal count sooner
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowReg   <= '0;
            epochReg <= 2'h0;
        end else if (ce) begin
            if (lowReg[32:24] >= tcountReg) begin
                lowReg   <= '0;
                epochReg <= epochReg + 2'h1;
            end else begin
                lowReg <= lowReg + {11'h000, incReg};
            end
        end
    end

    assign dropHead = dropReg;
    assign epoch    = epochReg;

    // Checks, sampled only on enabled edges
    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (!rst_n || !stickyRst_n);

    property p_sel;
        errMsg.valid |-> errMsg.severity != switch_timeout_pkg::SEV_NONE
            && errMsg.severity == selOf($past(reportCtrlReg), errMsg.queue);
    endproperty
    a_sel: assert property (p_sel)
        else $error("message severity does not match selector");

    property p_rise;
        $rose(pendReg[0]) |-> $rose(statusReg[0]);
    endproperty
    a_rise: assert property (p_rise)
        else $error("report pending without status edge");

    property p_ctrl_rst;
        $rose(stickyRst_n) |-> reportCtrlReg == switch_timeout_pkg::CTRL_RESET
            && tcountReg == switch_timeout_pkg::TERMINAL_COUNT_RESET
            && incReg == switch_timeout_pkg::INC_RESET;
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst)
        else $error("wrong power-on settings");

    property p_inc;
        dropReg[1] && cntReg[1] != switch_timeout_pkg::CNT_MAX && !cntClr
            |=> cntReg[1] == $past(cntReg[1]) + 8'h01;
    endproperty
    a_inc: assert property (p_inc)
        else $error("discard counter did not count");

    property p_sat;
        cntReg[2] == switch_timeout_pkg::CNT_MAX && !cntClr
            |=> cntReg[2] == switch_timeout_pkg::CNT_MAX;
    endproperty
    a_sat: assert property (p_sat)
        else $error("discard counter wrapped");

    property p_clr;
        cntClr && !dropReg[0] |=> cntReg[0] == 8'h00;
    endproperty
    a_clr: assert property (p_clr)
        else $error("counter not cleared by read");

    property p_clr_evt;
        cntClr && dropReg[0] |=> cntReg[0] == 8'h01;
    endproperty
    a_clr_evt: assert property (p_clr_evt)
        else $error("drop lost during counter read");

    property p_ts;
        lowReg[32:24] < tcountReg
            |=> lowReg == 33'($past(lowReg) + $past(incReg));
    endproperty
    a_ts: assert property (p_ts)
        else $error("time stamp step wrong");

    property p_epoch;
        lowReg[32:24] >= tcountReg
            |=> epochReg == 2'($past(epochReg) + 2'h1) && lowReg == '0;
    endproperty
    a_epoch: assert property (p_epoch)
        else $error("epoch did not advance at terminal count");

    property p_age;
        dropReg[0] |-> $past(queueHead[0].valid)
            && isOld($past(epochReg), $past(queueHead[0].epoch));
    endproperty
    a_age: assert property (p_age)
        else $error("packet dropped before two epochs");

    property p_stat;
        dropReg[2] |=> statusReg[2];
    endproperty
    a_stat: assert property (p_stat)
        else $error("status not set on drop");

    property p_en;
        !enableReg |=> dropReg == 4'h0;
    endproperty
    a_en: assert property (p_en)
        else $error("drop while time-outs disabled");

    c_fatal: cover property (errMsg.valid
        && errMsg.severity == switch_timeout_pkg::SEV_FATAL);
    c_sat: cover property (cntReg[0] == switch_timeout_pkg::CNT_MAX);
    c_epoch: cover property (lowReg[32:24] >= tcountReg);
    c_clr_evt: cover property (cntClr && dropReg != 4'h0);
endmodule

`default_nettype wire

// ### bench/root_msg_model.sv
// Root-side model that absorbs the block's time-out error messages
`timescale 1ns/1ps
`default_nettype none

module root_msg_model (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire switch_timeout_pkg::err_msg_t errMsg,
    output logic [31:0]                       msgCount,
    output logic [1:0]                        lastSev,
    output logic [1:0]                        lastQueue,
    output logic                              badMsg
);
    // Messages carry no back-pressure, so every pulse is taken at once
    always @(posedge clk) begin
        if (!rst_n) begin
            msgCount  <= 32'h0000_0000;
            lastSev   <= 2'h0;
            lastQueue <= 2'h0;
            badMsg    <= 1'b0;
        end else if (errMsg.valid === 1'b1) begin
            msgCount  <= msgCount + 32'h0000_0001;
            lastSev   <= errMsg.severity;
            lastQueue <= errMsg.queue;
            // A message of no severity is never legal on the link
            if (errMsg.severity == 2'h0) badMsg <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the switch time-out reporting block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
        logic [1:0]  resp;
    } row_t;

    logic                             clk;
    logic                             rst_n;
    logic                             stickyRst_n;
    logic [11:0]                      awaddr;
    logic [11:0]                      araddr;
    logic                             awvalid, awready, wvalid, wready;
    logic                             bvalid, bready, arvalid, arready;
    logic                             rvalid, rready;
    logic [31:0]                      wdata, rdata, msgCount, m0, rd;
    logic [3:0]                       wstrb, dropHead, flood;
    logic [1:0]                       bresp, rresp, epoch, lastSev, rs;
    logic [1:0]                       lastQueue, stamp;
    logic                             badMsg, hit, ce;
    switch_timeout_pkg::head_t [3:0]  queueHead;
    switch_timeout_pkg::err_msg_t     errMsg;
    logic [1:0]                       dropEp [4];
    int                               dropCnt [4];
    int                               err_count, checks, cycleCount, p;
    row_t                             rows [11];

    switch_timeout_report_stats #(.ADDR_W(12)) u_dut (
        .clk(clk), .rst_n(rst_n), .stickyRst_n(stickyRst_n), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .queueHead(queueHead), .dropHead(dropHead), .epoch(epoch),
        .errMsg(errMsg)
    );

    root_msg_model u_root (
        .clk(clk), .rst_n(rst_n), .errMsg(errMsg), .msgCount(msgCount),
        .lastSev(lastSev), .lastQueue(lastQueue), .badMsg(badMsg)
    );

    // Clock at 25 MHz
    always #20 clk = ~clk;

    // Queue side: pop on a drop; flood keeps an aged head in place
    always @(posedge clk) begin
        for (int q = 0; q < 4; q++) begin
            if (dropHead[q] === 1'b1) begin
                queueHead[q].valid <= flood[q];
                dropCnt[q] <= dropCnt[q] + 1;
                dropEp[q] <= epoch;
            end
            if (flood[q]) queueHead[q].epoch <= epoch - 2'h2;
        end
    end

    // Hang guard well above the expected run length
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Each channel is held until its own ready is sampled high
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        // Let an edge pass so the next call never re-raises in this step
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic push(input int q);
        stamp = epoch;
        queueHead[q] <= '{valid: 1'b1, epoch: epoch};
        @(posedge clk);
    endtask

    // Bounded wait for the next drop pulse of one queue
    task automatic wait_drop(input int q, input int limit);
        int n0, n;
        n0 = dropCnt[q];
        n = 0;
        while (dropCnt[q] == n0 && n < limit) begin
            @(posedge clk);
            n++;
        end
        hit = (dropCnt[q] != n0);
    endtask

    // Cycles between two epoch steps, measured over one whole interval
    task automatic epoch_period();
        logic [1:0] e;
        int         n;
        n = 0;
        e = epoch;
        while (epoch === e && n < 50) begin
            @(posedge clk);
            n++;
        end
        e = epoch;
        p = 0;
        while (epoch === e && p < 50) begin
            @(posedge clk);
            p++;
        end
        check("epoch step", {30'h0, epoch}, {30'h0, e + 2'h1});
    endtask

    initial begin
        rows = '{
            '{1'b0, 12'h750, 32'h0, 32'h0000_0001, 2'h0},
            '{1'b0, 12'h754, 32'h0, 32'h0000_0000, 2'h0},
            '{1'b0, 12'h758, 32'h0, 32'h0000_0082, 2'h0},
            '{1'b0, 12'h75C, 32'h0, 32'h0000_0000, 2'h0},
            '{1'b0, 12'h760, 32'h0, 32'h7740_0001, 2'h0},
            '{1'b1, 12'h758, 32'hFFFF_FF1B, 32'h0000_001B, 2'h0},
            '{1'b1, 12'h758, 32'h0000_00E4, 32'h0000_00E4, 2'h0},
            '{1'b1, 12'h760, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 2'h0},
            '{1'b1, 12'h75C, 32'hFFFF_FFFF, 32'h0000_0000, 2'h0},
            '{1'b1, 12'h700, 32'h1234_5678, 32'h0000_0000, 2'h2},
            '{1'b1, 12'h760, 32'h007F_FFFF, 32'h007F_FFFF, 2'h0}};
        clk = 0; rst_n = 0; stickyRst_n = 0; awaddr = 0; araddr = 0;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        wdata = 0; wstrb = 0; flood = 0; queueHead = '0; ce = 1;
        dropCnt = '{0, 0, 0, 0}; err_count = 0; checks = 0; cycleCount = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        stickyRst_n <= 1'b1;
        @(posedge clk);
        // Reset values, field access and the unmapped address
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].wdata, rs);
                check("write resp", {30'h0, rs}, {30'h0, rows[i].resp});
            end
            axi_read(rows[i].addr, rd, rs);
            check("read data", rd, rows[i].rexp);
            check("read resp", {30'h0, rs}, {30'h0, rows[i].resp});
        end
        // Step 0x3FFFFF against count 1: five adds then the wrap cycle
        epoch_period();
        check("epoch period", p, 6);
        axi_write(12'h760, 32'h0060_0000, rs);
        epoch_period();
        check("slow period", p, 9);
        axi_write(12'h760, 32'h007F_FFFF, rs);
        // One drop per queue; queue q reports with severity q
        for (int q = 0; q < 4; q++) begin
            m0 = msgCount;
            push(q);
            wait_drop(q, 60);
            check("drop seen", {31'h0, hit}, 32'h1);
            check("drop age", {31'h0, dropEp[q][1] ^ stamp[1]}, 32'h1);
            repeat (4) @(posedge clk);
            check("msg count", msgCount, m0 + (q != 0));
            if (q != 0) check("msg sev", {30'h0, lastSev}, q);
            if (q != 0) check("msg queue", {30'h0, lastQueue}, q);
        end
        axi_read(12'h754, rd, rs);
        check("status", rd, 32'h0000_000F);
        axi_read(12'h75C, rd, rs);
        check("counts", rd, 32'h0101_0101);
        axi_read(12'h75C, rd, rs);
        check("counts cleared", rd, 32'h0000_0000);
        // Status still set: a second drop counts but stays silent
        m0 = msgCount;
        push(1);
        wait_drop(1, 60);
        repeat (4) @(posedge clk);
        check("silent drop", msgCount, m0);
        axi_write(12'h754, 32'h0000_0002, rs);
        axi_read(12'h754, rd, rs);
        check("status clear", rd, 32'h0000_000D);
        push(1);
        wait_drop(1, 60);
        repeat (4) @(posedge clk);
        check("rearmed", msgCount, m0 + 32'h1);
        axi_read(12'h75C, rd, rs);
        check("second count", rd, 32'h0000_0200);
        // No discard while time-outs are disabled
        axi_write(12'h750, 32'h0000_0000, rs);
        push(2);
        wait_drop(2, 40);
        check("disabled", {31'h0, hit}, 32'h0);
        axi_write(12'h750, 32'h0000_0001, rs);
        wait_drop(2, 40);
        check("enabled", {31'h0, hit}, 32'h1);
        // Flood the posted queue well past the counter's maximum
        axi_read(12'h75C, rd, rs);
        flood[0] <= 1'b1;
        queueHead[0].valid <= 1'b1;
        // Clearing reads an odd number of cycles apart: one meets a drop
        axi_read(12'h75C, rd, rs);
        @(posedge clk);
        axi_read(12'h75C, rd, rs);
        p = 0;
        while (dropCnt[0] < 300 && p < 2000) begin
            @(posedge clk);
            p++;
        end
        flood[0] <= 1'b0;
        repeat (10) @(posedge clk);
        check("no bad msg", {31'h0, badMsg}, 32'h0);
        // Clock enable low freezes the time stamp and its epoch
        ce <= 1'b0;
        @(posedge clk);
        m0 = {30'h0, epoch};
        repeat (20) @(posedge clk);
        check("frozen epoch", {30'h0, epoch}, m0);
        ce <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axi_read(12'h75C, rd, rs);
        check("saturated", rd, 32'h0000_00FF);
        axi_read(12'h758, rd, rs);
        check("sticky ctrl", rd, 32'h0000_00E4);
        axi_read(12'h760, rd, rs);
        check("sticky stamp", rd, 32'h007F_FFFF);
        wrap_up();
    end
endmodule

`default_nettype wire
